// ==== include/pcg_pkg.sv ====
// constants and types for the loop clock generator
package pcg_pkg;
   // -------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------
   localparam logic [7:0] PCG_CTRL = 8'h00;
   localparam logic [7:0] PCG_LOOP = 8'h04;
   localparam logic [7:0] PCG_DIVA = 8'h08;
   localparam logic [7:0] PCG_DIVB = 8'h0C;
   localparam logic [7:0] PCG_DIVE = 8'h10;
   localparam logic [7:0] PCG_STAT = 8'h14;
   // -------------------------------------------------
   // control fields
   // -------------------------------------------------
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_CLEAR = 1;
   localparam int CTRL_GATE  = 2;
   localparam int CTRL_MODE  = 3;
   localparam int CTRL_CSEL  = 5;
   localparam int CTRL_EXTEN = 6;
   localparam int CTRL_DIFF  = 7;
   localparam int CTRL_GOUT  = 8;
   localparam int CTRL_GOE   = 9;
   localparam int LOOP_N     = 0;
   localparam int LOOP_M     = 8;
   localparam int LOOP_FTAP  = 16;
   localparam int DIV_HIGH   = 0;
   localparam int DIV_LOW    = 8;
   localparam int DIV_INIT   = 16;
   localparam int DIV_TAP    = 24;
   // -------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------
   localparam logic [31:0] CTRL_RST  = 32'h0000_0045;
   localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;
   localparam logic [31:0] LOOP_RST  = 32'h0000_0000;
   localparam logic [31:0] LOOP_MASK = 32'h0007_1F1F;
   localparam logic [31:0] DIV_RST   = 32'h0000_0000;
   localparam logic [31:0] DIV_MASK  = 32'h071F_1F1F;
   // -------------------------------------------------
   // oscillator and detector figures
   // -------------------------------------------------
   localparam int          TAPS         = 8;
   localparam int          STEP_MIN_PS  = 150;
   localparam int          STEP_MAX_PS  = 400;
   localparam logic [15:0] OSC_MIN      = 16'h0100;
   localparam logic [15:0] OSC_MAX      = 16'h1FFF;
   localparam logic [15:0] OSC_INIT     = 16'h0800;
   localparam logic [15:0] OSC_STEP     = 16'h0010;
   localparam logic [2:0]  LOCK_WINDOWS = 3'h4;
   localparam logic [4:0]  COMP_TICKS   = 5'h01;

   typedef enum logic [1:0] {
      PCG_NORMAL,
      PCG_ZDB,
      PCG_NOCOMP
   } pcg_mode_t;

   typedef struct packed {
      logic [2:0] tap;
      logic [4:0] init;
      logic [4:0] low;
      logic [4:0] high;
   } pcg_div_cfg_t;
endpackage : pcg_pkg

// ==== hdl/pcg_top.sv ====
// loop clock generator: oscillator model, detector, post-scale dividers, registers
`timescale 1ns/1ps
`default_nettype none

module pcg_post_div
   import pcg_pkg::*;
(
   // clock and control
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         hold_i,
   // tap event and setup
   input  wire logic         tick_i,
   input  wire pcg_div_cfg_t cfg_i,
   input  wire logic [4:0]   off_i,
   // divided clock
   output logic              clk_o
);
   logic [5:0] cnt_r;
   logic [5:0] hi;
   logic [5:0] per;
   logic [5:0] pre;
   logic [5:0] cnt_nxt;
   always_comb begin
      hi      = {1'b0, cfg_i.high} + 6'h01;
      per     = hi + {1'b0, cfg_i.low};
      pre     = 6'(({1'b0, cfg_i.init} + {1'b0, off_i}) % per);
      cnt_nxt = (cnt_r >= per - 6'h01) ? 6'h00 : cnt_r + 6'h01;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 6'h00;
         clk_o <= 1'b0;
      end else if (ce_i) begin
         if (hold_i) begin
            cnt_r <= pre;
            clk_o <= 1'b0;
         end else if (tick_i) begin
            cnt_r <= cnt_nxt;
            clk_o <= cnt_nxt < hi;
         end
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_high_end: assert property (ce_i && !hold_i && tick_i && cfg_i.low != 5'h00
      && cnt_r == hi - 6'h01 && cnt_r < per |=> !clk_o)
      else $error("high phase not ended at high count");
endmodule : pcg_post_div
module pcg_top
   import pcg_pkg::*;
(
   // clock, reset, freeze
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // loop control pins
   input  wire logic        ref_clk_i,
   input  wire logic        run_en_i,
   input  wire logic        clear_i,
   input  wire logic        phase_freq_detector_gate_i,
   // loop outputs
   output logic             glob_out_div_a_o,
   output logic             glob_out_div_b_o,
   output logic             lock_o,
   // external clock pin pair
   input  wire logic        ext_in_i,
   output logic             ext_clk_o,
   output logic             ext_oe_o,
   output logic             ext_clk_n_o,
   output logic             ext_n_oe_o
);
   import pcg_pkg::*;
   logic [31:0] ctrl_r, loop_r, diva_r, divb_r, dive_r;
   logic [15:0] osc_r, acc_r;
   logic [2:0]  tap_q_r, tap, match_cnt_r;
   logic [4:0]  nref_r;
   logic [5:0]  fbcnt_r, m_val;
   logic        ref_q_r, lock_r, ack_r, ext_div;
   logic        hold, gate_on, ref_rise, win_end, match, req;
   logic [2:0]  fb_tap;
   logic [2:0]  tick;
   logic [4:0]  off [3];
   pcg_div_cfg_t cfg [3];
   pcg_mode_t   mode;
   function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s, input logic [31:0] m);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r & m;
   endfunction : wmask
   // -------------------------------------------------
   // control decode
   // -------------------------------------------------
   always_comb begin
      hold = !(ctrl_r[CTRL_RUN] && run_en_i) || ctrl_r[CTRL_CLEAR] || clear_i;
      gate_on = ctrl_r[CTRL_GATE] && phase_freq_detector_gate_i;
      mode = pcg_mode_t'(ctrl_r[CTRL_MODE +: 2]);
      tap = acc_r[15:13];
      fb_tap = loop_r[LOOP_FTAP +: 3];
      m_val = {1'b0, loop_r[LOOP_M +: 5]} + 6'h01;
      ref_rise = ref_clk_i && !ref_q_r;
      win_end = ref_rise && nref_r == loop_r[LOOP_N +: 5];
      match = fbcnt_r == m_val;
      req = wb_cyc_i && wb_stb_i;
      cfg[0] = pcg_div_cfg_t'({diva_r[DIV_TAP +: 3], diva_r[DIV_INIT +: 5],
                               diva_r[DIV_LOW +: 5], diva_r[DIV_HIGH +: 5]});
      cfg[1] = pcg_div_cfg_t'({divb_r[DIV_TAP +: 3], divb_r[DIV_INIT +: 5],
                               divb_r[DIV_LOW +: 5], divb_r[DIV_HIGH +: 5]});
      cfg[2] = pcg_div_cfg_t'({dive_r[DIV_TAP +: 3], dive_r[DIV_INIT +: 5],
                               dive_r[DIV_LOW +: 5], dive_r[DIV_HIGH +: 5]});
      off[0] = 5'h00;
      off[1] = 5'h00;
      off[2] = 5'h00;
      case (mode)
         PCG_NORMAL: off[ctrl_r[CTRL_CSEL] ? 1 : 0] = COMP_TICKS;
         PCG_ZDB:    off[2] = COMP_TICKS;
         default:    off[0] = 5'h00;
      endcase
   end

   // -------------------------------------------------
   // oscillator: phase accumulator, eight taps
   // -------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_r   <= 16'h0000;
         tap_q_r <= 3'h0;
      end else if (ce_i) begin
         if (hold) begin
            acc_r   <= 16'h0000;
            tap_q_r <= 3'h0;
         end else begin
            acc_r   <= acc_r + osc_r;
            tap_q_r <= tap;
         end
      end
   end
   // each divider ticks once per oscillator period, on its own tap
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tick[i] = !hold && tap != tap_q_r && tap == cfg[i].tap;
      end
   end

   // -------------------------------------------------
   // detector: count feedback ticks per n+1 reference edges
   // -------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q_r <= 1'b0;
         nref_r  <= 5'h00;
         fbcnt_r <= 6'h00;
      end else if (ce_i) begin
         ref_q_r <= ref_clk_i;
         if (hold || win_end) begin
            nref_r  <= 5'h00;
            fbcnt_r <= 6'h00;
         end else begin
            if (ref_rise) begin
               nref_r <= nref_r + 5'h01;
            end
            if (tap != tap_q_r && tap == fb_tap && fbcnt_r != 6'h3F) begin
               fbcnt_r <= fbcnt_r + 6'h01;
            end
         end
      end
   end
   // control word: frozen while the detector gate is off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_r <= OSC_INIT;
      end else if (ce_i && gate_on && !hold && win_end && !match) begin
         if (fbcnt_r < m_val) begin
            osc_r <= (osc_r >= OSC_MAX - OSC_STEP) ? OSC_MAX : osc_r + OSC_STEP;
         end else begin
            osc_r <= (osc_r <= OSC_MIN + OSC_STEP) ? OSC_MIN : osc_r - OSC_STEP;
         end
      end
   end
   // lock: consecutive matching windows; one miss drops it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_cnt_r <= 3'h0;
         lock_r      <= 1'b0;
      end else if (ce_i) begin
         if (hold) begin
            match_cnt_r <= 3'h0;
            lock_r      <= 1'b0;
         end else if (win_end) begin
            match_cnt_r <= match ? ((match_cnt_r == LOCK_WINDOWS) ? match_cnt_r
                                    : match_cnt_r + 3'h1) : 3'h0;
            lock_r      <= match && match_cnt_r >= LOCK_WINDOWS - 3'h1;
         end
      end
   end
   assign lock_o = lock_r;
   // -------------------------------------------------
   // post-scale dividers
   // -------------------------------------------------
   logic [2:0] dclk;
   generate
      for (genvar g = 0; g < 3; g++) begin : g_div
         pcg_post_div u_div (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .hold_i (hold),
            .tick_i (tick[g]),
            .cfg_i  (cfg[g]),
            .off_i  (off[g]),
            .clk_o  (dclk[g])
         );
      end
   endgenerate
   assign glob_out_div_a_o = dclk[0];
   assign glob_out_div_b_o = dclk[1];
   assign ext_div = dclk[2];
   // external pin: divider output or plain gpio
   always_comb begin
      if (ctrl_r[CTRL_EXTEN]) begin
         ext_clk_o   = ext_div;
         ext_oe_o    = 1'b1;
         ext_clk_n_o = !ext_div;
         ext_n_oe_o  = ctrl_r[CTRL_DIFF];
      end else begin
         ext_clk_o   = ctrl_r[CTRL_GOUT];
         ext_oe_o    = ctrl_r[CTRL_GOE];
         ext_clk_n_o = 1'b0;
         ext_n_oe_o  = 1'b0;
      end
   end

   // -------------------------------------------------
   // wishbone registers, one-cycle ack
   // -------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r    <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_r   <= CTRL_RST;
         loop_r   <= LOOP_RST;
         diva_r   <= DIV_RST;
         divb_r   <= DIV_RST;
         dive_r   <= DIV_RST;
      end else if (ce_i) begin
         ack_r <= req && !ack_r;
         if (req && !ack_r && wb_we_i) begin
            case (wb_adr_i)
               PCG_CTRL: ctrl_r <= wmask(ctrl_r, wb_dat_i, wb_sel_i, CTRL_MASK);
               PCG_LOOP: loop_r <= wmask(loop_r, wb_dat_i, wb_sel_i, LOOP_MASK);
               PCG_DIVA: diva_r <= wmask(diva_r, wb_dat_i, wb_sel_i, DIV_MASK);
               PCG_DIVB: divb_r <= wmask(divb_r, wb_dat_i, wb_sel_i, DIV_MASK);
               PCG_DIVE: dive_r <= wmask(dive_r, wb_dat_i, wb_sel_i, DIV_MASK);
               default:  ;
            endcase
         end
         if (req && !ack_r) begin
            case (wb_adr_i)
               PCG_CTRL: wb_dat_o <= ctrl_r;
               PCG_LOOP: wb_dat_o <= loop_r;
               PCG_DIVA: wb_dat_o <= diva_r;
               PCG_DIVB: wb_dat_o <= divb_r;
               PCG_DIVE: wb_dat_o <= dive_r;
               PCG_STAT: wb_dat_o <= {osc_r, 13'h0000, ext_in_i, gate_on, lock_r};
               default:  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_r;
   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_held;
      hold && ce_i;
   endsequence

   a_hold_quiet: assert property (s_held |=> !glob_out_div_a_o && !glob_out_div_b_o
      && !lock_o && !ext_div) else $error("outputs or lock not cleared in hold");
   a_clear_reset: assert property (clear_i && ce_i |=> acc_r == 16'h0000
      && fbcnt_r == 6'h00) else $error("clear did not reset counters");
   a_resync_start: assert property (s_held ##1 !hold |-> acc_r == 16'h0000
      && match_cnt_r == 3'h0) else $error("restart not from phase zero");
   a_gate_freeze: assert property (!gate_on |=> $stable(osc_r))
      else $error("control word moved with gate off");
   a_lock_cause: assert property ($rose(lock_r) |-> $past(win_end) && $past(match))
      else $error("lock rose without matching window");
   a_osc_range: assert property (osc_r >= OSC_MIN && osc_r <= OSC_MAX)
      else $error("control word out of range");
   a_gpio_pin: assert property (!ctrl_r[CTRL_EXTEN] |-> ext_clk_o == ctrl_r[CTRL_GOUT]
      && ext_oe_o == ctrl_r[CTRL_GOE] && !ext_n_oe_o) else $error("gpio pin wrong");
   a_fb_tap: assert property (ce_i && !hold && !win_end && fbcnt_r < 6'h3E
      && tap != tap_q_r && tap == fb_tap |=> fbcnt_r == $past(fbcnt_r) + 6'h01)
      else $error("feedback tap not counted");
   a_wb_ack: assert property (req && !ack_r && ce_i |=> ack_r ##1 (!ack_r || !ce_i))
      else $error("ack not a single cycle");
endmodule : pcg_top
`default_nettype wire

// ==== tb/pcg_ref_model.sv ====
// reference clock source and fabric lock qualifier facing the loop block
`timescale 1ns/1ps
`default_nettype none

module pcg_ref_model #(
   parameter int HALF = 16,
   parameter int QUAL = 320
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // bench controls
   input  wire logic ref_on_i,
   input  wire logic gate_req_i,
   input  wire logic lock_i,
   // towards the loop
   output logic      ref_clk_o,
   output logic      gate_o,
   output logic      lock_ok_o
);
   int   half_cnt;
   int   qual_cnt;
   logic seen_r;

   // -----------------------------
   // reference clock, parked low while stopped
   // -----------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !ref_on_i) begin
         half_cnt  <= 0;
         ref_clk_o <= 1'b0;
      end else if (half_cnt == HALF - 1) begin
         half_cnt  <= 0;
         ref_clk_o <= ~ref_clk_o;
      end else begin
         half_cnt <= half_cnt + 1;
      end
   end

   // lock only counts once it has stood for QUAL cycles
   always_ff @(posedge clk_i) begin
      if (rst_i || !lock_i) begin
         qual_cnt <= 0;
      end else if (qual_cnt < QUAL) begin
         qual_cnt <= qual_cnt + 1;
      end
   end
   assign lock_ok_o = (qual_cnt == QUAL);

   // losing a qualified lock gates the detector off to hold frequency
   always_ff @(posedge clk_i) begin
      if (rst_i || !gate_req_i) begin
         seen_r <= 1'b0;
      end else if (lock_ok_o) begin
         seen_r <= 1'b1;
      end
   end
   assign gate_o = gate_req_i & ~(seen_r & ~lock_i);
endmodule : pcg_ref_model

`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the loop clock generator
`timescale 1ns/1ps
`default_nettype none

module tb;
   import pcg_pkg::*;
   localparam int OSCP = 65536 / int'(OSC_INIT);
   localparam int TAPP = OSCP / TAPS;
   localparam int PER  = 4 * OSCP;
   localparam int CMP  = int'(COMP_TICKS) * OSCP;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        ce_i     = 1'b1;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [3:0]  sel      = 4'hF;
   logic [31:0] wdat     = 32'h0000_0000;
   logic        run_en   = 1'b1;
   logic        clr      = 1'b0;
   logic        ext_in   = 1'b0;
   logic        ref_on   = 1'b1;
   logic        gate_req = 1'b0;
   logic [31:0] rdat, rd, cw;
   logic        ack, ref_clk, gate, lock, lock_ok, ga, gb, eo, eoe, en, enoe;
   int          n_fail     = 0;
   int          num_checks = 0;

   pcg_ref_model ref_u (.clk_i(clk_i), .rst_i(rst_i), .ref_on_i(ref_on), .gate_req_i(gate_req),
      .lock_i(lock), .ref_clk_o(ref_clk), .gate_o(gate), .lock_ok_o(lock_ok));
   pcg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ref_clk_i(ref_clk), .run_en_i(run_en), .clear_i(clr),
      .phase_freq_detector_gate_i(gate), .glob_out_div_a_o(ga), .glob_out_div_b_o(gb),
      .lock_o(lock), .ext_in_i(ext_in), .ext_clk_o(eo), .ext_oe_o(eoe),
      .ext_clk_n_o(en), .ext_n_oe_o(enoe));

   always #25 clk_i = ~clk_i;

   // -----------------------------
   // shared tasks
   // -----------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic tmo();
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop();
   endtask : tmo

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] divw(input int h, input int l, input int i, input int tp);
      return (32'(tp) << DIV_TAP) | (32'(i) << DIV_INIT) | (32'(l) << DIV_LOW) | 32'(h - 1);
   endfunction : divw

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int i;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      if (i == 50) tmo();
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask : rdc

   // counts falling edges until output a (s=0), b (s=1) or external (s=2) changes to lvl
   task automatic wait_lvl(input int s, input logic lvl, output int t);
      logic p, v;
      for (t = 1; t <= 3000; t++) begin
         p = (s == 2) ? eo : (s == 1) ? gb : ga;
         @(negedge clk_i);
         v = (s == 2) ? eo : (s == 1) ? gb : ga;
         if (v === lvl && p !== lvl) break;
      end
      if (t > 3000) tmo();
      @(posedge clk_i);
   endtask : wait_lvl

   task automatic restart();
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (2 * PER) @(posedge clk_i);
   endtask : restart

   task automatic gap_case(input logic [31:0] ctrl, input logic [31:0] divb, input int md,
                           input int exp);
      int t, d;
      wr(PCG_CTRL, ctrl);
      wr(PCG_DIVA, divw(2, 2, 0, 0));
      wr(PCG_DIVB, divb);
      restart();
      wait_lvl(0, 1'b1, t);
      wait_lvl(1, 1'b1, d);
      check(32'(d % md), 32'(exp));
   endtask : gap_case

   task automatic quiet();
      int i, n;
      n = 0;
      gate_req <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (i = 0; i < 200; i++) begin
         @(negedge clk_i);
         if ((ga | gb | lock | eo) !== 1'b0) n++;
      end
      @(posedge clk_i);
      check(32'(n), 32'h0);
   endtask : quiet

   task automatic wait_lock(input int lim);
      int i, n;
      gate_req <= 1'b1;
      for (i = 0; i < lim; i++) begin
         @(posedge clk_i);
         if (lock_ok === 1'b1) break;
      end
      if (i == lim) tmo();
      n = 0;
      for (i = 0; i < 300; i++) begin
         @(posedge clk_i);
         if (ga === 1'b1) n++;
      end
      check(32'(n > 0 && n < 300), 32'h1);
   endtask : wait_lock

   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_regs();
      rdc(PCG_CTRL, CTRL_RST);
      rdc(PCG_DIVB, DIV_RST);
      wr(PCG_LOOP, 32'hFFFF_FFFF);
      rdc(PCG_LOOP, LOOP_MASK);
      wr(PCG_LOOP, LOOP_RST);
      wr(PCG_DIVE, 32'hFFFF_FFFF);
      rdc(PCG_DIVE, DIV_MASK);
      wr(8'h18, 32'hFFFF_FFFF);
      rdc(8'h18, 32'h0000_0000);
   endtask : t_regs

   task automatic t_ext();
      int i, n, t;
      wr(PCG_CTRL, 32'h0000_0305);
      check(32'({eo, eoe}), 32'h3);
      ext_in <= 1'b1;
      repeat (2) @(posedge clk_i);
      wb(1'b0, PCG_STAT, 32'h0, rd);
      check(32'(rd[2]), 32'h1);
      wr(PCG_DIVE, divw(1, 1, 0, 0));
      wr(PCG_CTRL, 32'h0000_00C5);
      n = 0;
      t = 0;
      for (i = 0; i < 200; i++) begin
         @(negedge clk_i);
         if (en !== ~eo || eoe !== 1'b1 || enoe !== 1'b1) n++;
         if (eo === 1'b1) t++;
      end
      @(posedge clk_i);
      check(32'(n), 32'h0);
      check(32'(t > 0 && t < 200), 32'h1);
   endtask : t_ext

   task automatic t_duty();
      int t, th, tl;
      wr(PCG_CTRL, 32'h0000_0055);
      wr(PCG_DIVA, divw(3, 5, 0, 0));
      restart();
      wait_lvl(0, 1'b1, t);
      wait_lvl(0, 1'b0, th);
      wait_lvl(0, 1'b1, tl);
      check(32'(th), 32'(3 * OSCP));
      check(32'(tl), 32'(5 * OSCP));
   endtask : t_duty

   task automatic t_phase();
      int t, d;
      for (int k = 0; k < TAPS; k++) begin
         gap_case(32'h55, divw(2, 2, 0, k), OSCP, (k * TAPP) % OSCP);
      end
      gap_case(32'h55, divw(2, 2, 1, 0), PER, PER - OSCP);
      gap_case(32'h45, divw(2, 2, 0, 0), PER, CMP);
      gap_case(32'h65, divw(2, 2, 0, 0), PER, PER - CMP);
      gap_case(32'h55, divw(2, 2, 0, 0), PER, 0);
      gap_case(32'h5D, divw(2, 2, 0, 0), PER, 0);
      wr(PCG_DIVE, divw(2, 2, 0, 0));
      gap_case(32'h4D, divw(2, 2, 0, 0), PER, 0);
      wait_lvl(0, 1'b1, t);
      wait_lvl(2, 1'b1, d);
      check(32'(d % PER), 32'(PER - CMP));
   endtask : t_phase

   task automatic t_hold();
      wr(PCG_DIVA, divw(1, 1, 0, 0));
      wr(PCG_CTRL, 32'h0000_0045);
      wait_lock(5000);
      wb(1'b0, PCG_STAT, 32'h0, rd);
      check(32'(rd[0]), 32'h1);
      run_en <= 1'b0;
      quiet();
      run_en <= 1'b1;
      wait_lock(5000);
      clr <= 1'b1;
      quiet();
      clr <= 1'b0;
      wait_lock(5000);
      wr(PCG_CTRL, 32'h0000_0047);
      quiet();
      wr(PCG_CTRL, 32'h0000_0044);
      quiet();
      wr(PCG_CTRL, 32'h0000_0045);
      wait_lock(5000);
   endtask : t_hold

   task automatic t_freeze();
      int w;
      gate_req <= 1'b0;
      ref_on   <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, PCG_STAT, 32'h0, cw);
      w = int'(cw[31:16]);
      repeat (400) @(posedge clk_i);
      wb(1'b0, PCG_STAT, 32'h0, rd);
      check(32'(rd[31:16]), 32'(cw[31:16]));
      wr(PCG_CTRL, 32'h0000_0041);
      wait_lvl(0, 1'b1, rd);
      wait_lvl(0, 1'b1, rd);
      // two oscillator periods at the held control word, one clock of phase residue
      check(32'(int'(rd) * w > 2 * 65536 - w && int'(rd) * w < 2 * 65536 + w), 32'h1);
   endtask : t_freeze

   task automatic t_mult();
      int e;
      e = 2 * int'(OSC_INIT);
      ref_on <= 1'b1;
      wr(PCG_CTRL, 32'h0000_0045);
      wr(PCG_LOOP, 32'h0000_0100);
      clr <= 1'b1;
      quiet();
      clr <= 1'b0;
      wait_lock(20000);
      wb(1'b0, PCG_STAT, 32'h0, rd);
      check(32'(int'(rd[31:16]) > e - 256 && int'(rd[31:16]) < e + 256), 32'h1);
   endtask : t_mult

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_ext();
      t_duty();
      t_phase();
      t_hold();
      t_freeze();
      t_mult();
      report_and_stop();
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      tmo();
   end
endmodule : tb

`default_nettype wire
